// >>> card_detect_general_control_tb_top.sv
/*
 self-checking bench of the card detect and general control register.
 assumes the package, design and card model are compiled first.
*/
`timescale 1ns/1ps
module card_detect_general_control_tb_top;
   logic clk = 1'b0; // 100 MHz
   logic rst_b = 1'b0;
   cdgc_pkg::cdgc_req_t req = '0;
   cdgc_pkg::cdgc_card_t card;
   logic en = 1'b0, fcm = 1'b0, present = 1'b1;
   logic [1:0] vs = 2'b10; // {second, first} sense level
   logic [7:0] rdata, rd;
   logic csc, pulse, wake, rsel, rmv;
   int error_cnt = 0, checks_done = 0, cyc = 0, rmv_cnt = 0;
   initial forever #5 clk = ~clk;
   cdgc_card_model card_u (.i_present(present), .i_vs(vs), .o_card(card));
   cdgc_top dut_u (.i_clk(clk), .i_rst_b(rst_b), .i_req(req),
      .i_card(card), .i_cd_int_enable(en), .i_flag_clear_mode(fcm),
      .o_rdata(rdata), .o_card_detect_csc(csc), .o_soft_cd_pulse(pulse),
      .o_ring_indicate_wake_out(wake), .o_reset_on_removal_select(rsel),
      .o_removal_reset(rmv));
   // hang guard; tests need under a hundred cycles
   // falling edge keeps the pulse count clear of the launch edge
   always @(negedge clk) begin
      cyc++;
      if (rmv === 1'b1) rmv_cnt++; // removal pulses seen
      if (cyc == 3000) begin
         error_cnt++;
         end_sim();
      end
   end
   task automatic chk(input string nm, input logic [7:0] got, exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // one bus access, request held for exactly one taking edge
   task automatic acc(input logic r, w, input logic [7:0] a, d);
      @(posedge clk) #1;
      req = '{rd: r, wr: w, addr: a, wdata: d};
      @(posedge clk) #1;
      req = '0;
      rd = rdata;
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic t_status();
      acc(1, 0, 8'h16, 8'h00);
      chk("rd_reset", rd, 8'h80);
      chk("wake_reset", 8'(wake), 8'h01);
      vs = 2'b01;
      wait_cyc(5);
      acc(1, 0, 8'h16, 8'h00);
      chk("rd_vs", rd, 8'h40);
      $display("status test done");
   endtask
   task automatic t_ctrl();
      acc(0, 1, 8'h16, 8'hff);
      chk("rsel", 8'(rsel), 8'h01);
      chk("csc_ignored", 8'(csc), 8'h00);
      chk("pulse_ignored", 8'(pulse), 8'h00);
      acc(1, 0, 8'h16, 8'h00);
      chk("rd_ctrl", rd, 8'h52);
      $display("control test done");
   endtask
   task automatic t_trig();
      en = 1'b1;
      fcm = 1'b1;
      acc(0, 1, 8'h16, 8'h30);
      chk("pulse", 8'(pulse), 8'h01);
      chk("csc_set", 8'(csc), 8'h01);
      wait_cyc(1);
      chk("pulse_end", 8'(pulse), 8'h00);
      acc(1, 0, 8'h04, 8'h00);
      chk("csc_kept", 8'(csc), 8'h01);
      acc(0, 1, 8'h04, 8'h08);
      chk("csc_wclr", 8'(csc), 8'h00);
      acc(1, 0, 8'h16, 8'h00);
      chk("rd_trig", rd, 8'h50);
      $display("trigger test done");
   endtask
   task automatic t_wake();
      fcm = 1'b0;
      acc(0, 1, 8'h16, 8'h12);
      present = 1'b0;
      wait_cyc(8);
      chk("wake_low", 8'(wake), 8'h00);
      chk("rmv_cnt", 8'(rmv_cnt), 8'h01);
      wait_cyc(10);
      chk("wake_held", 8'(wake), 8'h00);
      acc(1, 0, 8'h04, 8'h00);
      wait_cyc(1);
      chk("csc_rclr", 8'(csc), 8'h00);
      chk("wake_free", 8'(wake), 8'h01);
      acc(0, 1, 8'h16, 8'h00);
      present = 1'b1;
      wait_cyc(8);
      chk("csc_ins", 8'(csc), 8'h01);
      chk("wake_off", 8'(wake), 8'h01);
      chk("rmv_ins", 8'(rmv_cnt), 8'h01);
      acc(1, 0, 8'h04, 8'h00);
      present = 1'b0;
      wait_cyc(8);
      chk("csc_rm2", 8'(csc), 8'h01);
      chk("wake_dis", 8'(wake), 8'h01);
      chk("rmv_off", 8'(rmv_cnt), 8'h01);
      acc(1, 0, 8'h16, 8'h00);
      chk("rd_vs_hi", rd, 8'hc0);
      $display("wake test done");
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // reset 16 cycles, then four edges before the first request
   initial begin
      wait_cyc(16);
      rst_b = 1'b1;
      wait_cyc(3);
      t_status();
      t_ctrl();
      t_trig();
      t_wake();
      end_sim();
   end
endmodule // card_detect_general_control_tb_top

// >>> cdgc_card_model.sv
/*
 card slot partner: card-detect and voltage-sense pins of the card.
 assumes the bench chooses presence and the sense levels.
*/
`timescale 1ns/1ps
module cdgc_card_model (
   input wire logic i_present,
   input wire logic [1:0] i_vs,
   output cdgc_pkg::cdgc_card_t o_card
);
   // detect pins low when seated; empty slot leaves all pins pulled up
   assign o_card = i_present ? {i_vs, 2'h0} : 4'hf;
endmodule // cdgc_card_model

// >>> cdgc_consts.svh
/*
 holds offsets, bit positions and reset values of the card detect
 and general control register, plus the functional notes.
 assumes inclusion by bare name from the top module.
*/
// Functional notes
// - bit 7 reads live second voltage-sense level
// - bit 6 reads live first voltage-sense level
// - write 1 bit 5 raises card-detect change
// - trigger ignored while card-detect enable clear
// - trigger bit write-only, reads zero, self-clearing
// - explicit-clear mode write also clears trigger
// - wake enable plus detect change drives wake low
// - wake stays low until change flag cleared; the code also releases it when wake enable is cleared
// - bit 1 selects register reset on removal
// - bits 3, 2, 0 read zero, ignore writes
// - all control bits zero after reset
// - flag clears on read or explicit write
`ifndef CDGC_CONSTS_SVH
`define CDGC_CONSTS_SVH
`define CDGC_OFFSET 8'h16
`define CDGC_CSC_OFFSET 8'h04
`define CDGC_BIT_VS2 7
`define CDGC_BIT_VS1 6
`define CDGC_BIT_TRIG 5
`define CDGC_BIT_WAKE 4
`define CDGC_BIT_RSEL 1
`define CDGC_CSC_BIT_CD 3
`define CDGC_RESET_CTRL 1'b0
// edges after reset release until synchroniser and history hold pins
`define CDGC_SYNC_FILL 2'h3
`endif

// >>> cdgc_pkg.sv
/*
 types shared by the card detect and general control block.
 assumes the constants header sits in the same folder.
*/
package cdgc_pkg;
   // card-side input levels, grouped
   typedef struct packed {
      logic vs2;
      logic vs1;
      logic [1:0] cd;
   } cdgc_card_t;
   // host register access
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cdgc_req_t;
endpackage

// >>> cdgc_top.sv
/*
 card detect and general control register of one socket: voltage-sense
 status, software card-detect trigger, wake output and removal select.
 assumes a single-cycle index bus from the host, card pins asynchronous,
 and interrupt enable / flag-clear mode provided by neighbouring logic.
*/
`timescale 1ns/1ps
`include "cdgc_consts.svh"
module cdgc_top (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire cdgc_pkg::cdgc_req_t i_req,
   input wire cdgc_pkg::cdgc_card_t i_card,
   input wire logic i_cd_int_enable,
   input wire logic i_flag_clear_mode,
   output logic [7:0] o_rdata,
   output logic o_card_detect_csc,
   output logic o_soft_cd_pulse,
   output logic o_ring_indicate_wake_out,
   output logic o_reset_on_removal_select,
   output logic o_removal_reset
);
   // reset release through two flops
   logic rst_s1_q, rst_b_q;
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rst_s1_q <= 1'b0;
         rst_b_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_b_q <= rst_s1_q;
      end
   end

   // two-flop synchroniser for card pins
   cdgc_pkg::cdgc_card_t card_s1_q, card_q;
   always_ff @(posedge i_clk or negedge rst_b_q) begin
      if (!rst_b_q) begin
         card_s1_q <= '0;
         card_q <= '0;
      end else begin
         card_s1_q <= i_card;
         card_q <= card_s1_q;
      end
   end

   // previous detect level for change sensing
   logic [1:0] cd_prev_q; // detect pins one cycle back
   logic [1:0] fill_q; // edges since reset release, saturating
   logic cd_valid; // synchroniser and history hold real samples
   logic cd_change; // any detect pin moved
   // history of the detect pins
   always_ff @(posedge i_clk or negedge rst_b_q) begin
      if (!rst_b_q) begin
         cd_prev_q <= 2'h0;
      end else begin
         cd_prev_q <= card_q.cd;
      end
   end
   // sync flops reset to zero while an empty slot idles high, so
   // changes stay masked until both sync stages and the history are
   // loaded; otherwise an empty slot fakes a change after reset
   always_ff @(posedge i_clk or negedge rst_b_q) begin
      if (!rst_b_q) begin
         fill_q <= 2'h0;
      end else if (fill_q != `CDGC_SYNC_FILL) begin
         fill_q <= fill_q + 2'h1;
      end
   end
   assign cd_valid = (fill_q == `CDGC_SYNC_FILL);
   assign cd_change = cd_valid && (cd_prev_q != card_q.cd);
   // removal: detect lines leave the seated level 00
   logic removal;
   assign removal = cd_valid && (cd_prev_q == 2'h0) &&
                    (card_q.cd != 2'h0);

   // access decode
   logic wr_me, rd_csc, wr_csc;
   assign wr_me = i_req.wr && (i_req.addr == `CDGC_OFFSET);
   assign rd_csc = i_req.rd && (i_req.addr == `CDGC_CSC_OFFSET);
   assign wr_csc = i_req.wr && (i_req.addr == `CDGC_CSC_OFFSET);

   // control bits, only 4 and 1 are storage
   logic wake_en_q, rsel_q;
   always_ff @(posedge i_clk or negedge rst_b_q) begin
      if (!rst_b_q) begin
         wake_en_q <= `CDGC_RESET_CTRL;
         rsel_q <= `CDGC_RESET_CTRL;
      end else if (wr_me) begin
         wake_en_q <= i_req.wdata[`CDGC_BIT_WAKE];
         rsel_q <= i_req.wdata[`CDGC_BIT_RSEL];
      end
   end
   assign o_reset_on_removal_select = rsel_q;

   // software trigger: one pulse, never stored (also what a csc
   // explicit clear would wipe, so nothing persists)
   logic trig;
   assign trig = wr_me && i_req.wdata[`CDGC_BIT_TRIG] &&
                 i_cd_int_enable;
   logic trig_clear;
   assign trig_clear = i_flag_clear_mode && wr_csc &&
                       i_req.wdata[`CDGC_CSC_BIT_CD];

   // card-detect change flag; set beats clear
   logic csc_q;
   logic csc_clr;
   always_comb begin
      if (i_flag_clear_mode)
         csc_clr = trig_clear;
      else
         csc_clr = rd_csc;
   end
   always_ff @(posedge i_clk or negedge rst_b_q) begin
      if (!rst_b_q) begin
         csc_q <= 1'b0;
      end else if (trig || cd_change) begin
         csc_q <= 1'b1;
      end else if (csc_clr) begin
         csc_q <= 1'b0;
      end
   end
   assign o_card_detect_csc = csc_q;

   // pulse register for the trigger event
   logic pulse_q;
   always_ff @(posedge i_clk or negedge rst_b_q) begin
      if (!rst_b_q) pulse_q <= 1'b0;
      else pulse_q <= trig && !trig_clear;
   end
   assign o_soft_cd_pulse = pulse_q;

   // wake output, low while armed event pending
   logic wake_low_q;
   always_ff @(posedge i_clk or negedge rst_b_q) begin
      if (!rst_b_q) begin
         wake_low_q <= 1'b0;
      end else if (!wake_en_q) begin
         wake_low_q <= 1'b0;
      end else if (cd_change) begin
         wake_low_q <= 1'b1;
      end else if (csc_clr) begin
         wake_low_q <= 1'b0;
      end
   end
   assign o_ring_indicate_wake_out = !wake_low_q;

   // removal reset pulse for the socket's compatibility registers
   logic rem_q;
   always_ff @(posedge i_clk or negedge rst_b_q) begin
      if (!rst_b_q) rem_q <= 1'b0;
      else rem_q <= removal && rsel_q;
   end
   assign o_removal_reset = rem_q;

   // read data: registered, reserved bits zero, trigger reads zero
   always_ff @(posedge i_clk or negedge rst_b_q) begin
      if (!rst_b_q) begin
         o_rdata <= 8'h00;
      end else if (i_req.rd && i_req.addr == `CDGC_OFFSET) begin
         o_rdata <= {card_q.vs2, card_q.vs1, 1'b0, wake_en_q,
                     2'b00, rsel_q, 1'b0};
      end else begin
         o_rdata <= 8'h00;
      end
   end

   // checks: each property names its own clock and reset copy
   // multi-step checks are built from the named sequences below

   // a detect pin change has cleared the synchroniser and the history
   sequence s_detect_moved;
      cd_change;
   endsequence

   // the card-detect change flag is up
   sequence s_flag_up;
      csc_q;
   endsequence

   // wake held low, still enabled, and no clear of the flag arriving
   sequence s_wake_holding;
      !o_ring_indicate_wake_out && wake_en_q && !csc_clr;
   endsequence

   // a clear of the flag that no new detect change overrides
   sequence s_clean_clear;
      wake_en_q && csc_clr && !cd_change;
   endsequence

   // an accepted trigger followed by a quiet cycle; back to back
   // triggers are legal, so only a lone one has a clean pulse shape
   sequence s_lone_trigger;
      trig ##1 !trig;
   endsequence

   // the trigger output rises for exactly one cycle
   sequence s_trig_pulse;
      o_soft_cd_pulse ##1 !o_soft_cd_pulse;
   endsequence

   // a card pulled while the reset-on-removal select is set
   sequence s_armed_removal;
      removal && rsel_q;
   endsequence

   // the removal reset rises for exactly one cycle
   sequence s_removal_pulse;
      o_removal_reset ##1 !o_removal_reset;
   endsequence

   // set wins, so an accepted trigger always leaves the flag up
   a_trig_sets_flag: assert property (
      @(posedge i_clk) disable iff (!rst_b_q) trig |=> csc_q)
      else $error("trigger did not set flag");

   // with the card-detect enable clear the write stays silent
   a_trig_ignored: assert property (
      @(posedge i_clk) disable iff (!rst_b_q)
      (wr_me && !i_cd_int_enable && !csc_q && !cd_change) |=>
      !pulse_q && !csc_q)
      else $error("trigger acted while disabled");

   // the trigger is write-only and always reads back as zero
   a_trig_reads_zero: assert property (
      @(posedge i_clk) disable iff (!rst_b_q)
      1'b1 |-> !o_rdata[`CDGC_BIT_TRIG])
      else $error("trigger bit read nonzero");

   // a lone trigger gives exactly one pulse and nothing persists
   a_trig_single: assert property (
      @(posedge i_clk) disable iff (!rst_b_q)
      s_lone_trigger |-> s_trig_pulse)
      else $error("trigger pulse not single");

   // reserved positions never carry anything
   a_reserved_zero: assert property (
      @(posedge i_clk) disable iff (!rst_b_q)
      o_rdata[3:2] == 2'h0 && !o_rdata[0])
      else $error("reserved bits nonzero");

   // an armed detect change pulls the wake output low
   a_wake_falls: assert property (
      @(posedge i_clk) disable iff (!rst_b_q)
      (wake_en_q && cd_change) |=> !o_ring_indicate_wake_out)
      else $error("wake did not fall");

   // once low and still enabled, wake stays low until the flag is cleared
   a_wake_holds: assert property (
      @(posedge i_clk) disable iff (!rst_b_q)
      s_wake_holding |=> !o_ring_indicate_wake_out)
      else $error("wake released early");

   // clearing the flag lets the wake output return high
   a_wake_release: assert property (
      @(posedge i_clk) disable iff (!rst_b_q)
      s_clean_clear |=> o_ring_indicate_wake_out)
      else $error("wake not released by clear");

   // with the resume enable off the wake output idles high
   a_wake_disabled: assert property (
      @(posedge i_clk) disable iff (!rst_b_q)
      !wake_en_q |=> o_ring_indicate_wake_out)
      else $error("wake low while disabled");

   // a synchronised detect change always reaches the flag
   a_change_sets_flag: assert property (
      @(posedge i_clk) disable iff (!rst_b_q)
      s_detect_moved |=> s_flag_up)
      else $error("detect change lost");

   // no removal reset while the select is clear
   a_rm_select: assert property (
      @(posedge i_clk) disable iff (!rst_b_q)
      (removal && !rsel_q) |=> !o_removal_reset)
      else $error("removal reset while deselected");

   // with the select set, a removal gives one reset pulse
   a_removal_single: assert property (
      @(posedge i_clk) disable iff (!rst_b_q)
      s_armed_removal |=> s_removal_pulse)
      else $error("removal reset pulse wrong");

   // the select bit follows each write to this register
   a_select_write: assert property (
      @(posedge i_clk) disable iff (!rst_b_q)
      wr_me |=> o_reset_on_removal_select ==
      $past(i_req.wdata[`CDGC_BIT_RSEL]))
      else $error("removal select not written");

   // control bits read back what was stored
   a_ctrl_readback: assert property (
      @(posedge i_clk) disable iff (!rst_b_q)
      (i_req.rd && i_req.addr == `CDGC_OFFSET) |=>
      o_rdata[`CDGC_BIT_WAKE] == $past(wake_en_q) &&
      o_rdata[`CDGC_BIT_RSEL] == $past(rsel_q))
      else $error("control readback wrong");

   // sense bits show the synchronised pin levels of the read cycle
   a_vs_live: assert property (
      @(posedge i_clk) disable iff (!rst_b_q)
      (i_req.rd && i_req.addr == `CDGC_OFFSET) |=>
      o_rdata[7:6] == $past({card_q.vs2, card_q.vs1}))
      else $error("voltage sense readback wrong");

   // read-clear mode: a read with no new event drops the flag
   a_read_clear: assert property (
      @(posedge i_clk) disable iff (!rst_b_q)
      (!i_flag_clear_mode && rd_csc && !trig && !cd_change) |=> !csc_q)
      else $error("read did not clear flag");

   // write-clear mode: a read alone leaves the flag up
   a_read_keeps: assert property (
      @(posedge i_clk) disable iff (!rst_b_q)
      (i_flag_clear_mode && rd_csc && csc_q) |=> csc_q)
      else $error("flag cleared by read in write mode");

   // write-clear mode: writing 1 to the detect bit drops the flag
   a_write_clear: assert property (
      @(posedge i_clk) disable iff (!rst_b_q)
      (trig_clear && !cd_change) |=> !csc_q)
      else $error("explicit clear did not drop flag");

   // a removal reset only ever follows a removal
   a_removal_cause: assert property (
      @(posedge i_clk) disable iff (!rst_b_q)
      o_removal_reset |-> $past(removal))
      else $error("removal reset without removal");
endmodule // cdgc_top
